// >>> logic/canom_mode_ctrl.sv
// Operating-mode controller for a CAN protocol controller
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: Software requests a mode through mode_request, control register bits 10:8.
// RULE2: The mode in force reads back in mode_status, bits 7:5, read-only.
// RULE3: Mode and status hold until the bus is idle for 11 recessive bits.
// RULE4: Initialization mode: no traffic, error counters cleared, interrupt flags kept.
// RULE5: Configuration registers are writable only in initialization mode.
// RULE6: Entry to initialization waits until a running transmission ends.
// RULE7: Disable mode: no traffic, wake flag on bus activity, counters kept.
// RULE8: Request 001 waits for idle bus, then enters disable and shows 001.
// RULE9: In disable mode both pins return to general-purpose I/O.
// RULE10: Wake low-pass filter on receive input when wake_lowpass_enable bit 14 set. The code filters only while sleep_in is also high.
// RULE11: Disable during the post-entry idle wait aborts transmission, flags abort.
// RULE12: Request 000 enters normal mode and takes both pins for the bus.
// RULE13: Listen-only: transmit pin released, no error flags or acks, counters frozen.
// RULE14: Request 111 accepts any message and ignores errors.
// RULE15: Loopback ties internal transmit to internal receive and releases both pins.
// RULE16: Initialization, listen-only and loopback codes are 100, 011 and 010.
module canom_mode_ctrl
   import canom_pkg::*;
#(
   parameter logic [2:0] INIT_CODE = CANOM_MODE_INIT,
   parameter logic [2:0] LISTEN_CODE = CANOM_MODE_LISTEN,
   parameter logic [2:0] LOOP_CODE = CANOM_MODE_LOOP
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // CAN pins
   input wire logic can_rx_pin_in,
   output logic can_tx_pin_out,
   output logic can_tx_pin_oe_out,
   output logic can_rx_pin_own_out,
   // Protocol engine side
   input wire logic engine_tx_in,
   input wire logic tx_busy_in,
   input wire logic tx_err_inc_in,
   input wire logic rx_err_inc_in,
   input wire logic sleep_in,
   output logic engine_rx_out,
   output logic tx_enable_out,
   output logic rx_enable_out,
   output logic ack_err_enable_out,
   output logic accept_all_out,
   output logic tx_start_out,
   // Interrupt
   output logic irq_out
);
   // ----------------------------------------------------------------
   // State and declarations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CANOM_ST_INIT = 4'b0001,
      CANOM_ST_RUN = 4'b0010,
      CANOM_ST_DIS = 4'b0100,
      CANOM_ST_WAIT = 4'b1000
   } canom_state_t;
   canom_state_t state_reg, state_next;
   logic [2:0] req_reg;
   logic [2:0] mode_reg, mode_next;
   logic wakflt_reg;
   logic tx_request_flag_reg, tx_aborted_flag_reg;
   logic [2:0] irq_stat_reg, irq_mask_reg;
   logic [7:0] tec_reg, rec_reg;
   logic [7:0] bit_cnt_reg;
   logic bit_tick;
   logic [2:0] rx_sync_reg;
   logic rx_level_reg;
   logic [2:0] wake_cnt_reg;
   logic txwait_reg;
   logic bus_idle, idle_raw;
   logic rx_internal;
   logic [31:0] cfg_rdata;
   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire access = psel_in && penable_in;
   wire wr = access && pwrite_in;
   wire hit_ctrl = paddr_in == CANOM_CTRL1_OFF;
   wire hit_cfg2 = paddr_in == CANOM_CFG2_OFF;
   wire hit_tx = paddr_in == CANOM_TXCTL_OFF;
   wire hit_ist = paddr_in == CANOM_IRQ_STAT_OFF;
   wire hit_imk = paddr_in == CANOM_IRQ_MASK_OFF;
   wire hit_err = paddr_in == CANOM_ERRCNT_OFF;
   wire [7:0] cfg_rel = paddr_in - CANOM_CFG_BASE_OFF;
   wire hit_cfg = paddr_in >= CANOM_CFG_BASE_OFF && cfg_rel[7:2] < 6'(CANOM_CFG_REGS) && cfg_rel[1:0] == 2'h0;
   wire mapped = hit_ctrl | hit_cfg2 | hit_tx | hit_ist | hit_imk | hit_err | hit_cfg;
   wire in_init = mode_reg == INIT_CODE;
   wire cfg_wr_ok = wr && hit_cfg && in_init; // RULE5
   wire cfg2_wr_ok = wr && hit_cfg2 && in_init; // RULE5
   // Reads of the lock-protected store take one wait cycle
   logic rd_wait_reg;
   assign pready_out = !(access && !pwrite_in && hit_cfg && !rd_wait_reg);
   assign pslverr_out = access && (!mapped || (pwrite_in && (hit_cfg || hit_cfg2) && !in_init));
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rd_wait_reg <= 1'b0;
      end else begin
         rd_wait_reg <= access && !pwrite_in && hit_cfg && !rd_wait_reg;
      end
   end
   // ----------------------------------------------------------------
   // Configuration store
   // ----------------------------------------------------------------
   canom_cfg_mem u_cfg (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .wr_en_in(cfg_wr_ok),
      .wr_idx_in(cfg_rel[4:2]),
      .wr_data_in(pwdata_in),
      .rd_idx_in(cfg_rel[4:2]),
      .rd_data_out(cfg_rdata)
   );
   // ----------------------------------------------------------------
   // Receive pin synchroniser and bit-rate divider
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rx_sync_reg <= 3'h7;
         rx_level_reg <= 1'b1;
         bit_cnt_reg <= 8'h0;
      end else begin
         rx_sync_reg <= {rx_sync_reg[1:0], can_rx_pin_in};
         if (rx_sync_reg[2] == rx_sync_reg[1]) begin
            rx_level_reg <= rx_sync_reg[1];
         end
         bit_cnt_reg <= bit_tick ? 8'h0 : bit_cnt_reg + 8'h1;
      end
   end
   assign bit_tick = bit_cnt_reg == 8'(CANOM_BIT_CYCLES - 1);
   // Loopback feeds the engine its own transmit level
   assign rx_internal = (mode_reg == LOOP_CODE) ? engine_tx_in : rx_level_reg; // RULE15
   assign engine_rx_out = rx_internal;
   canom_idle_det u_idle (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .bit_tick_in(bit_tick),
      .rx_in(rx_internal && mode_next == mode_reg), // RULE11
      .idle_out(idle_raw)
   );
   assign bus_idle = idle_raw && !tx_busy_in; // RULE6
   // ----------------------------------------------------------------
   // Mode state machine
   // ----------------------------------------------------------------
   wire req_change = req_reg != mode_reg;
   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      unique case (state_reg)
         CANOM_ST_INIT, CANOM_ST_RUN, CANOM_ST_DIS: begin
            if (req_change) begin
               state_next = CANOM_ST_WAIT;
            end
         end
         CANOM_ST_WAIT: begin
            if (!req_change || bus_idle) begin // RULE3 RULE8
               mode_next = req_reg;
               state_next = (req_reg == INIT_CODE) ? CANOM_ST_INIT :
                            (req_reg == CANOM_MODE_DISABLE) ? CANOM_ST_DIS : CANOM_ST_RUN;
            end
         end
         default: begin
            state_next = CANOM_ST_INIT;
            mode_next = INIT_CODE;
         end
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= CANOM_ST_INIT;
         mode_reg <= CANOM_RESET_MODE;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next; // RULE2 RULE16
      end
   end
   wire entered = mode_next != mode_reg;
   // ----------------------------------------------------------------
   // Mode-dependent controls and pin ownership
   // ----------------------------------------------------------------
   wire m_active = mode_reg != INIT_CODE && mode_reg != CANOM_MODE_DISABLE; // RULE3
   wire m_normal = m_active && mode_reg == CANOM_MODE_NORMAL; // RULE12
   wire m_listen = m_active && mode_reg == LISTEN_CODE; // RULE13
   wire m_all = m_active && mode_reg == CANOM_MODE_ALL; // RULE14
   wire m_loop = m_active && mode_reg == LOOP_CODE;
   wire tx_capable = m_normal || m_loop;
   assign tx_enable_out = tx_capable; // RULE4 RULE7
   assign rx_enable_out = m_normal || m_listen || m_all || m_loop;
   assign ack_err_enable_out = m_normal || m_loop; // RULE13 RULE14
   assign accept_all_out = m_all; // RULE14
   assign can_tx_pin_oe_out = m_normal; // RULE9 RULE13 RULE15
   assign can_tx_pin_out = m_normal ? engine_tx_in : 1'b1;
   assign can_rx_pin_own_out = m_normal || m_listen || m_all; // RULE9 RULE15
   assign tx_start_out = tx_capable && tx_request_flag_reg && !txwait_reg;
   // ----------------------------------------------------------------
   // Transmit request, start wait and abort
   // ----------------------------------------------------------------
   wire tx_wr = wr && hit_tx;
   wire abort = txwait_reg && tx_request_flag_reg && req_reg == CANOM_MODE_DISABLE; // RULE11
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tx_request_flag_reg <= 1'b0;
         tx_aborted_flag_reg <= 1'b0;
         txwait_reg <= 1'b0;
      end else begin
         if (entered) begin
            txwait_reg <= 1'b1;
         end else if (idle_raw) begin
            txwait_reg <= 1'b0;
         end
         if (abort) begin
            tx_request_flag_reg <= 1'b0; // RULE11
         end else if (tx_wr) begin
            tx_request_flag_reg <= pwdata_in[CANOM_TX_REQUEST_FLAG_BIT];
         end
         if (abort) begin
            tx_aborted_flag_reg <= 1'b1;
         end else if (tx_wr && pwdata_in[CANOM_TX_ABORTED_FLAG_BIT]) begin
            tx_aborted_flag_reg <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Error counters
   // ----------------------------------------------------------------
   wire cnt_run = m_normal || m_loop; // RULE13
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tec_reg <= 8'h0;
         rec_reg <= 8'h0;
      end else if (in_init) begin
         tec_reg <= 8'h0; // RULE4
         rec_reg <= 8'h0;
      end else if (cnt_run) begin
         tec_reg <= (tx_err_inc_in && tec_reg != 8'hFF) ? tec_reg + 8'h1 : tec_reg;
         rec_reg <= (rx_err_inc_in && rec_reg != 8'hFF) ? rec_reg + 8'h1 : rec_reg;
      end
   end
   // ----------------------------------------------------------------
   // Wake detection with optional low-pass filter
   // ----------------------------------------------------------------
   wire filt_on = wakflt_reg && sleep_in; // RULE10
   wire wake_seen = !rx_level_reg && (!filt_on || wake_cnt_reg == 3'(CANOM_WAKE_FLT_CYCLES));
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         wake_cnt_reg <= 3'h0;
      end else if (rx_level_reg) begin
         wake_cnt_reg <= 3'h0;
      end else if (wake_cnt_reg != 3'(CANOM_WAKE_FLT_CYCLES)) begin
         wake_cnt_reg <= wake_cnt_reg + 3'h1; // RULE10
      end
   end
   // ----------------------------------------------------------------
   // Control registers and interrupt status
   // ----------------------------------------------------------------
   wire [2:0] irq_evt;
   assign irq_evt[CANOM_IRQ_WAKE] = (mode_reg == CANOM_MODE_DISABLE) && wake_seen; // RULE7
   assign irq_evt[CANOM_IRQ_ABORT] = abort;
   assign irq_evt[CANOM_IRQ_MODE] = entered;
   wire [2:0] irq_clr = (wr && hit_ist) ? pwdata_in[2:0] : 3'h0;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         req_reg <= CANOM_RESET_MODE;
         wakflt_reg <= 1'b0;
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
      end else begin
         if (wr && hit_ctrl) begin
            req_reg <= pwdata_in[CANOM_REQ_LSB +: 3]; // RULE1
         end
         if (cfg2_wr_ok) begin
            wakflt_reg <= pwdata_in[CANOM_WAKFLT_BIT];
         end
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt; // RULE4
         if (wr && hit_imk) begin
            irq_mask_reg <= pwdata_in[2:0];
         end
      end
   end
   assign irq_out = |(irq_stat_reg & irq_mask_reg);
   // ----------------------------------------------------------------
   // Read data mux
   // ----------------------------------------------------------------
   wire [31:0] rd_ctrl = {21'h0, req_reg, mode_reg, 5'h0}; // RULE2
   wire [31:0] rd_cfg2 = {17'h0, wakflt_reg, 14'h0};
   wire [31:0] rd_tx = {30'h0, tx_aborted_flag_reg, tx_request_flag_reg};
   wire [31:0] rd_err = {16'h0, rec_reg, tec_reg};
   assign prdata_out = hit_ctrl ? rd_ctrl :
                       hit_cfg2 ? rd_cfg2 :
                       hit_tx ? rd_tx :
                       hit_ist ? {29'h0, irq_stat_reg} :
                       hit_imk ? {29'h0, irq_mask_reg} :
                       hit_err ? rd_err :
                       hit_cfg ? cfg_rdata : 32'h0;
endmodule : canom_mode_ctrl
`default_nettype wire

// >>> logic/canom_pkg.sv
// Package of constants for the CAN operating-mode controller
package canom_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CANOM_CTRL1_OFF = 8'h00;
   localparam logic [7:0] CANOM_CFG2_OFF = 8'h04;
   localparam logic [7:0] CANOM_TXCTL_OFF = 8'h08;
   localparam logic [7:0] CANOM_IRQ_STAT_OFF = 8'h0C;
   localparam logic [7:0] CANOM_IRQ_MASK_OFF = 8'h10;
   localparam logic [7:0] CANOM_ERRCNT_OFF = 8'h14;
   localparam logic [7:0] CANOM_CFG_BASE_OFF = 8'h20;
   localparam int CANOM_CFG_REGS = 6;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CANOM_REQ_LSB = 8;
   localparam int CANOM_STAT_LSB = 5;
   localparam int CANOM_WAKFLT_BIT = 14;
   localparam int CANOM_TX_REQUEST_FLAG_BIT = 0;
   localparam int CANOM_TX_ABORTED_FLAG_BIT = 1;
   localparam int CANOM_IRQ_WAKE = 0;
   localparam int CANOM_IRQ_ABORT = 1;
   localparam int CANOM_IRQ_MODE = 2;
   // ----------------------------------------------------------------
   // Mode codes
   // ----------------------------------------------------------------
   localparam logic [2:0] CANOM_MODE_NORMAL = 3'h0;
   localparam logic [2:0] CANOM_MODE_DISABLE = 3'h1;
   localparam logic [2:0] CANOM_MODE_LOOP = 3'h2;
   localparam logic [2:0] CANOM_MODE_LISTEN = 3'h3;
   localparam logic [2:0] CANOM_MODE_INIT = 3'h4;
   localparam logic [2:0] CANOM_MODE_ALL = 3'h7;
   // ----------------------------------------------------------------
   // Timing and reset values
   // ----------------------------------------------------------------
   localparam int CANOM_IDLE_BITS = 11;
   localparam int CANOM_BIT_RATE_KBPS = 1000;
   localparam int CANOM_CLK_MHZ = 250;
   localparam int CANOM_BIT_CYCLES = (CANOM_CLK_MHZ * 1000) / CANOM_BIT_RATE_KBPS;
   localparam int CANOM_WAKE_FLT_CYCLES = 4;
   localparam logic [2:0] CANOM_RESET_MODE = 3'h4;
endpackage : canom_pkg

// >>> logic/canom_idle_det.sv
// Bus-idle detector counting consecutive recessive bit times
`timescale 1ns/1ps
`default_nettype none
module canom_idle_det
   import canom_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Bit-rate enable and receive level
   input wire logic bit_tick_in,
   input wire logic rx_in,
   // Idle indication
   output logic idle_out
);
   logic [3:0] count_reg;
   logic [3:0] count_next;
   // Count recessive bit samples, restart on any dominant level
   assign count_next = !rx_in ? 4'h0 :
                       (bit_tick_in && count_reg != 4'(CANOM_IDLE_BITS)) ? count_reg + 4'h1 : count_reg;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count_reg <= 4'h0;
      end else begin
         count_reg <= count_next;
      end
   end
   assign idle_out = (count_reg == 4'(CANOM_IDLE_BITS));
endmodule : canom_idle_det
`default_nettype wire

// >>> logic/canom_cfg_mem.sv
// Small lock-protected configuration register store
`timescale 1ns/1ps
`default_nettype none
module canom_cfg_mem
   import canom_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Write port
   input wire logic wr_en_in,
   input wire logic [2:0] wr_idx_in,
   input wire logic [31:0] wr_data_in,
   // Read port
   input wire logic [2:0] rd_idx_in,
   output logic [31:0] rd_data_out
);
   logic [31:0] mem_reg [CANOM_CFG_REGS];
   // One storage word per configuration register
   genvar i;
   generate
      for (i = 0; i < CANOM_CFG_REGS; i++) begin : g_word
         always_ff @(posedge clk_in) begin
            if (reset_in) begin
               mem_reg[i] <= 32'h0;
            end else if (wr_en_in && wr_idx_in == 3'(i)) begin
               mem_reg[i] <= wr_data_in;
            end
         end
      end
   endgenerate
   // Registered read data
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rd_data_out <= 32'h0;
      end else begin
         rd_data_out <= (rd_idx_in < 3'(CANOM_CFG_REGS)) ? mem_reg[rd_idx_in] : 32'h0;
      end
   end
endmodule : canom_cfg_mem
`default_nettype wire

// >>> sim/canom_mode_ctrl_checker.sv
// Checker of port behaviour for the CAN operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module canom_mode_ctrl_checker
   import canom_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic pready_out,
   // Pins and engine side
   input wire logic can_rx_pin_in,
   input wire logic can_tx_pin_out,
   input wire logic can_tx_pin_oe_out,
   input wire logic can_rx_pin_own_out,
   input wire logic engine_tx_in,
   input wire logic tx_busy_in,
   input wire logic engine_rx_out,
   input wire logic tx_enable_out,
   input wire logic rx_enable_out,
   input wire logic ack_err_enable_out,
   input wire logic accept_all_out,
   input wire logic tx_start_out
);
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   logic [11:0] rec_cnt_reg;
   wire cfg_rd = !pwrite_in && paddr_in >= 8'h20 && paddr_in <= 8'h34;
   // Consecutive recessive cycles at the pin, saturating
   always_ff @(posedge clk_in) begin
      if (reset_in || !can_rx_pin_in) rec_cnt_reg <= 12'h000;
      else if (rec_cnt_reg != 12'hFFF) rec_cnt_reg <= rec_cnt_reg + 12'h001;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   ready_first_a: assert property (psel_in && !penable_in && !cfg_rd ##1 psel_in && penable_in |-> pready_out)
      else $error("access not answered in first cycle");
   cfg_wait_a: assert property (psel_in && !penable_in && cfg_rd ##1 psel_in && penable_in |-> !pready_out ##1 pready_out)
      else $error("config read wait state wrong");
   idle_wait_a: assert property ($changed(can_tx_pin_oe_out) |-> rec_cnt_reg >= 12'h9C4)
      else $error("mode changed without idle bus");
   init_defer_a: assert property ($fell(can_tx_pin_oe_out) |-> !$past(tx_busy_in))
      else $error("mode left during transmission");
   tx_drive_a: assert property (can_tx_pin_oe_out |-> can_tx_pin_out == engine_tx_in && can_rx_pin_own_out && tx_enable_out)
      else $error("normal mode pin drive wrong");
   tx_release_a: assert property (!can_tx_pin_oe_out |-> can_tx_pin_out)
      else $error("released transmit pin not recessive");
   loop_route_a: assert property (tx_enable_out && !can_tx_pin_oe_out |-> engine_rx_out == engine_tx_in)
      else $error("loopback route broken");
   quiet_off_a: assert property (!can_rx_pin_own_out && !tx_enable_out |-> !rx_enable_out && !tx_start_out)
      else $error("traffic in init or disable");
   listen_quiet_a: assert property (!tx_enable_out |-> !ack_err_enable_out && !tx_start_out)
      else $error("passive mode sends acks");
   accept_all_a: assert property (accept_all_out |-> can_rx_pin_own_out && !tx_enable_out)
      else $error("accept all outside listen-all");
   // Main scenarios
   cover property ($rose(can_tx_pin_oe_out));
   cover property ($rose(accept_all_out));
   cover property (tx_enable_out && !can_tx_pin_oe_out);
endmodule : canom_mode_ctrl_checker
bind canom_mode_ctrl canom_mode_ctrl_checker u_chk (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
   .can_rx_pin_in(can_rx_pin_in), .can_tx_pin_out(can_tx_pin_out), .can_tx_pin_oe_out(can_tx_pin_oe_out),
   .can_rx_pin_own_out(can_rx_pin_own_out), .engine_tx_in(engine_tx_in), .tx_busy_in(tx_busy_in),
   .engine_rx_out(engine_rx_out), .tx_enable_out(tx_enable_out), .rx_enable_out(rx_enable_out),
   .ack_err_enable_out(ack_err_enable_out), .accept_all_out(accept_all_out), .tx_start_out(tx_start_out));
`default_nettype wire

// >>> sim/canom_bus_node.sv
// Behavioural CAN bus with chattering far nodes
`timescale 1ns/1ps
`default_nettype none
module canom_bus_node
   import canom_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Traffic command and device driver
   input wire logic chatter_in,
   input wire logic tx_in,
   input wire logic tx_oe_in,
   // Bus level seen by the device
   output logic rx_out
);
   int bit_cnt;
   logic level_reg;
   // Far nodes flip the level once per bit time while chattering
   always_ff @(posedge clk_in) begin
      if (reset_in || !chatter_in) begin
         bit_cnt <= 0;
         level_reg <= 1'b1;
      end else if (bit_cnt == CANOM_BIT_CYCLES - 1) begin
         bit_cnt <= 0;
         level_reg <= ~level_reg;
      end else begin
         bit_cnt <= bit_cnt + 1;
      end
   end
   // Wired-AND with pull-up: recessive unless someone drives dominant
   assign rx_out = level_reg & (tx_oe_in ? tx_in : 1'b1);
endmodule : canom_bus_node
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking testbench of the CAN operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench
   import canom_pkg::*;
;
   logic clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd_val;
   logic engine_tx_in = 1'b1, tx_busy_in = 1'b0, tx_err_inc_in = 1'b0, rx_err_inc_in = 1'b0;
   logic sleep_in = 1'b0, chatter = 1'b0, rd_err, can_rx_pin_in;
   logic pready_out, pslverr_out, can_tx_pin_out, can_tx_pin_oe_out, can_rx_pin_own_out, engine_rx_out;
   logic tx_enable_out, rx_enable_out, ack_err_enable_out, accept_all_out, tx_start_out, irq_out;
   int n_errors = 0, checks = 0, cyc = 0, i, r;
   // Rows: mode code, then tx drive, rx own, tx enable, accept all
   logic [6:0] rows [0:5] = '{7'h0E, 7'h22, 7'h34, 7'h75, 7'h10, 7'h40};
   always #2 clk_in = ~clk_in;
   canom_mode_ctrl DUT (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .can_rx_pin_in(can_rx_pin_in),
      .can_tx_pin_out(can_tx_pin_out), .can_tx_pin_oe_out(can_tx_pin_oe_out),
      .can_rx_pin_own_out(can_rx_pin_own_out), .engine_tx_in(engine_tx_in), .tx_busy_in(tx_busy_in),
      .tx_err_inc_in(tx_err_inc_in), .rx_err_inc_in(rx_err_inc_in), .sleep_in(sleep_in),
      .engine_rx_out(engine_rx_out), .tx_enable_out(tx_enable_out), .rx_enable_out(rx_enable_out),
      .ack_err_enable_out(ack_err_enable_out), .accept_all_out(accept_all_out),
      .tx_start_out(tx_start_out), .irq_out(irq_out));
   canom_bus_node u_bus (.clk_in(clk_in), .reset_in(reset_in), .chatter_in(chatter),
      .tx_in(can_tx_pin_out), .tx_oe_in(can_tx_pin_oe_out), .rx_out(can_rx_pin_in));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task tally_and_finish;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; waits for pready, takes data at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do @(posedge clk_in);
      while (pready_out !== 1'b1);
      rd_val = prdata_out;
      rd_err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   // Read one register
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // Request a mode and poll status until it shows
   task automatic set_mode(input logic [2:0] c);
      apb(1'b1, CANOM_CTRL1_OFF, {21'h0, c, 8'h0});
      while (rd_val[7:5] !== c) rd(CANOM_CTRL1_OFF);
   endtask : set_mode
   // Hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      rd(CANOM_CTRL1_OFF);
      chk(rd_val, 32'h480);
      chk(32'({irq_out, can_tx_pin_oe_out, can_tx_pin_out}), 32'h1);
      apb(1'b1, CANOM_CTRL1_OFF, 32'h4E0);
      rd(CANOM_CTRL1_OFF);
      chk(rd_val, 32'h480);
      apb(1'b1, CANOM_CFG_BASE_OFF + 8'h04, 32'hA5A55A5A);
      rd(CANOM_CFG_BASE_OFF + 8'h04);
      chk(rd_val, 32'hA5A55A5A);
      apb(1'b1, CANOM_CFG2_OFF, 32'h4000);
      rd(CANOM_CFG2_OFF);
      chk(rd_val, 32'h4000);
      rd(8'hFC);
      chk({rd_err, rd_val[30:0]}, 32'h80000000);
      $display("reset and register test done");
      apb(1'b1, CANOM_IRQ_MASK_OFF, 32'h4);
      for (r = 0; r < 6; r++) begin
         set_mode(rows[r][6:4]);
         chk(32'(rd_val[7:5]), 32'(rows[r][6:4]));
         chk(32'({can_tx_pin_oe_out, can_rx_pin_own_out, tx_enable_out, accept_all_out}), 32'(rows[r][3:0]));
         repeat (4) @(posedge clk_in) engine_tx_in <= ~engine_tx_in;
      end
      chk(32'(irq_out), 32'h1);
      apb(1'b1, CANOM_IRQ_STAT_OFF, 32'h7);
      @(posedge clk_in);
      chk(32'(irq_out), 32'h0);
      $display("mode table test done");
      set_mode(CANOM_MODE_NORMAL);
      apb(1'b1, CANOM_CFG_BASE_OFF + 8'h04, 32'h0);
      chk(32'(rd_err), 32'h1);
      rd(CANOM_CFG_BASE_OFF + 8'h04);
      chk(rd_val, 32'hA5A55A5A);
      for (i = 0; i < 3; i++) begin
         @(posedge clk_in);
         tx_err_inc_in <= 1'b1;
         rx_err_inc_in <= (i < 2);
         @(posedge clk_in);
         tx_err_inc_in <= 1'b0;
         rx_err_inc_in <= 1'b0;
      end
      set_mode(CANOM_MODE_DISABLE);
      rd(CANOM_ERRCNT_OFF);
      chk(rd_val, 32'h203);
      sleep_in <= 1'b1;
      chatter <= 1'b1;
      apb(1'b1, CANOM_CTRL1_OFF, 32'h0);
      repeat (3500) @(posedge clk_in);
      rd(CANOM_CTRL1_OFF);
      chk(32'(rd_val[7:5]), 32'h1);
      rd(CANOM_IRQ_STAT_OFF);
      chk(32'(rd_val[0]), 32'h1);
      chatter <= 1'b0;
      sleep_in <= 1'b0;
      set_mode(CANOM_MODE_NORMAL);
      $display("lock, counter and wake test done");
      tx_busy_in <= 1'b1;
      apb(1'b1, CANOM_CTRL1_OFF, 32'h400);
      repeat (3500) @(posedge clk_in);
      rd(CANOM_CTRL1_OFF);
      chk(32'(rd_val[7:5]), 32'h0);
      tx_busy_in <= 1'b0;
      set_mode(CANOM_MODE_INIT);
      rd(CANOM_ERRCNT_OFF);
      chk(rd_val, 32'h0);
      set_mode(CANOM_MODE_NORMAL);
      apb(1'b1, CANOM_TXCTL_OFF, 32'h1);
      set_mode(CANOM_MODE_DISABLE);
      rd(CANOM_TXCTL_OFF);
      chk(32'(rd_val[1:0]), 32'h2);
      rd(CANOM_IRQ_STAT_OFF);
      chk(32'(rd_val[1]), 32'h1);
      $display("defer and abort test done");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
